// >>> spi_register_access_port.sv
// Serial slave port giving register, burst and FIFO access
// Notes on behaviour
// - Slave only, mode zero, clock idles low
// - Single access: address byte, one data byte
// - Burst: address steps by one per byte
// - FIFO address stays fixed for whole frame
// - Input captured on rising serial clock edge
// - Output updated on each falling clock edge
// - Select low starts frame; output undriven when high
// - First byte: write flag, seven-bit address
// - Data bytes shifted most significant bit first
// - Further bytes need no new address
// - Select rising ends frame; next byte addresses
// - Write returns register content before the write
module spi_register_access_port
	import spi_port_pkg::*;
#(
	parameter int REG_COUNT = DOC_REG_COUNT,
	parameter int FIFO_DEPTH = DOC_FIFO_DEPTH
) (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic spi_clk_in,
	input wire logic chip_select_n_in,
	input wire logic mosi_in,
	output logic miso_out,
	output logic miso_oe_out,
	output logic wr_valid_out,
	output logic [ADDR_W-1:0] wr_addr_out,
	output logic [BYTE_W-1:0] wr_data_out,
	input wire logic wr_ready_in,
	input wire logic rd_valid_in,
	input wire logic [BYTE_W-1:0] rd_data_in,
	output logic rd_ready_out
);
	if (REG_COUNT < 1 || REG_COUNT > DOC_REG_COUNT) begin : g_bad_count
		$error("spi_register_access_port: REG_COUNT out of range");
	end

	localparam int FIFO_LOG = $clog2(FIFO_DEPTH);
	if (FIFO_DEPTH < 4 || (1 << FIFO_LOG) != FIFO_DEPTH) begin : g_bad_depth
		$error("spi_register_access_port: FIFO_DEPTH not a power of two");
	end

	////////////////////////////////////////////////////////////////////////
	// Core domain reset: asserts at once, releases on clk_in edges only
	// Pin may rise close to an edge; the chain keeps recovery clean
	logic [2:0] core_rst_sync_reg;
	logic [2:0] core_rst_sync_next;
	logic core_rst_n;

	always_comb begin
		core_rst_sync_next = {core_rst_sync_reg[1:0], 1'b1};
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			core_rst_sync_reg <= 3'h0;
		end else begin
			core_rst_sync_reg <= core_rst_sync_next;
		end
	end

	assign core_rst_n = core_rst_sync_reg[2];

	////////////////////////////////////////////////////////////////////////
	// Link domain: frame state on the rising serial clock edge
	typedef enum logic [0:0] {
		PHASE_ADDR = 1'b0,
		PHASE_DATA = 1'b1
	} phase_t;

	phase_t phase_reg;
	phase_t phase_next;
	logic frame_rst_n;
	logic [2:0] bit_cnt_reg;
	logic [2:0] bit_cnt_next;
	logic [BYTE_W-2:0] shift_in_reg;
	logic [BYTE_W-2:0] shift_in_next;
	logic write_reg;
	logic write_next;
	logic [ADDR_W-1:0] addr_reg;
	logic [ADDR_W-1:0] addr_next;
	logic [BYTE_W-1:0] in_byte;
	logic in_data;
	logic byte_done;
	logic data_done;
	logic at_fifo;
	logic mirror_we;

	// Select high holds the frame logic in reset, so each frame restarts
	assign frame_rst_n = rst_n_in & ~chip_select_n_in;

	assign in_byte = {shift_in_reg, mosi_in};
	assign in_data = phase_reg == PHASE_DATA;
	assign byte_done = bit_cnt_reg == BIT_LAST;
	assign data_done = byte_done & in_data;
	assign at_fifo = addr_reg == FIFO_ADDR;
	assign mirror_we = data_done & write_reg & ~at_fifo;

	// Address phase lasts one byte; data phase lasts until select rises
	always_comb begin
		phase_next = phase_reg;
		case (phase_reg)
			PHASE_ADDR: begin
				if (byte_done) begin
					phase_next = PHASE_DATA;
				end
			end
			PHASE_DATA: begin
				phase_next = PHASE_DATA;
			end
			default: begin
				phase_next = PHASE_ADDR;
			end
		endcase
	end

	always_ff @(posedge spi_clk_in or negedge frame_rst_n) begin
		if (!frame_rst_n) begin
			phase_reg <= PHASE_ADDR;
		end else begin
			phase_reg <= phase_next;
		end
	end

	always_comb begin
		bit_cnt_next = bit_cnt_reg + BIT_STEP;
		shift_in_next = in_byte[BYTE_W-2:0];
		write_next = write_reg;
		addr_next = addr_reg;
		if (byte_done && !in_data) begin
			write_next = in_byte[BYTE_W-1];
			addr_next = in_byte[ADDR_W-1:0];
		end else if (data_done && !at_fifo) begin
			addr_next = addr_reg + ADDR_STEP;
		end
	end

	// Mode zero capture: rising edge of the serial clock
	always_ff @(posedge spi_clk_in or negedge frame_rst_n) begin
		if (!frame_rst_n) begin
			bit_cnt_reg <= BIT_FIRST;
			shift_in_reg <= '0;
			write_reg <= 1'b0;
			addr_reg <= ADDR_RESET;
		end else begin
			bit_cnt_reg <= bit_cnt_next;
			shift_in_reg <= shift_in_next;
			write_reg <= write_next;
			addr_reg <= addr_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Register mirror in the link domain, so reads answer within half a bit
	logic [BYTE_W-1:0] mirror_reg [REG_COUNT];
	logic [BYTE_W-1:0] mirror_next [REG_COUNT];
	logic [BYTE_W-1:0] mirror_sel;

	for (genvar i = 0; i < REG_COUNT; i++) begin : g_mirror
		always_comb begin
			mirror_next[i] = mirror_reg[i];
			if (mirror_we && addr_reg == ADDR_W'(i)) begin
				mirror_next[i] = in_byte;
			end
		end

		always_ff @(posedge spi_clk_in or negedge rst_n_in) begin
			if (!rst_n_in) begin
				mirror_reg[i] <= REG_RESET;
			end else begin
				mirror_reg[i] <= mirror_next[i];
			end
		end
	end

	always_comb begin
		mirror_sel = IDLE_BYTE;
		if (32'(addr_reg) < REG_COUNT) begin
			mirror_sel = mirror_reg[addr_reg];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Crossings: writes out to the core, FIFO read bytes in from the core
	logic push_valid;
	logic [MSG_W-1:0] push_data;
	logic drain_valid;
	logic drain_ready;
	logic [MSG_W-1:0] drain_data;
	logic fetch_valid;
	logic fetch_ready;
	logic [BYTE_W-1:0] fetch_data;

	// Serial clock cannot stall; a write with the FIFO full is lost
	assign push_valid = data_done & write_reg;
	assign push_data = {addr_reg, in_byte};
	assign fetch_ready = data_done & ~write_reg & at_fifo;

	spi_port_fifo #(
		.WIDTH(MSG_W),
		.DEPTH(FIFO_DEPTH)
	) u_write_fifo (
		.wr_clk_in(spi_clk_in),
		.wr_rst_n_in(rst_n_in),
		.wr_valid_in(push_valid),
		.wr_data_in(push_data),
		.wr_ready_out(),
		.rd_clk_in(clk_in),
		.rd_rst_n_in(core_rst_n),
		.rd_valid_out(drain_valid),
		.rd_data_out(drain_data),
		.rd_ready_in(drain_ready)
	);

	spi_port_fifo #(
		.WIDTH(BYTE_W),
		.DEPTH(FIFO_DEPTH)
	) u_read_fifo (
		.wr_clk_in(clk_in),
		.wr_rst_n_in(core_rst_n),
		.wr_valid_in(rd_valid_in),
		.wr_data_in(rd_data_in),
		.wr_ready_out(rd_ready_out),
		.rd_clk_in(spi_clk_in),
		.rd_rst_n_in(rst_n_in),
		.rd_valid_out(fetch_valid),
		.rd_data_out(fetch_data),
		.rd_ready_in(fetch_ready)
	);

	////////////////////////////////////////////////////////////////////////
	// Link domain: output shifter on the falling serial clock edge
	logic [BYTE_W-1:0] tx_shift_reg;
	logic [BYTE_W-1:0] tx_shift_next;
	logic [BYTE_W-1:0] tx_byte;

	always_comb begin
		tx_byte = mirror_sel;
		if (at_fifo) begin
			tx_byte = fetch_valid ? fetch_data : IDLE_BYTE;
		end
	end

	always_comb begin
		tx_shift_next = {tx_shift_reg[BYTE_W-2:0], 1'b0};
		if (bit_cnt_reg == BIT_FIRST && in_data) begin
			tx_shift_next = tx_byte;
		end else if (!in_data) begin
			tx_shift_next = IDLE_BYTE;
		end
	end

	always_ff @(negedge spi_clk_in or negedge frame_rst_n) begin
		if (!frame_rst_n) begin
			tx_shift_reg <= IDLE_BYTE;
		end else begin
			tx_shift_reg <= tx_shift_next;
		end
	end

	assign miso_out = tx_shift_reg[BYTE_W-1];
	// Enable follows select directly; a flop would miss the first bit
	assign miso_oe_out = ~chip_select_n_in;

	////////////////////////////////////////////////////////////////////////
	// Core domain: registered write notification stage
	logic out_valid_reg, out_valid_next;
	logic [ADDR_W-1:0] out_addr_reg, out_addr_next;
	logic [BYTE_W-1:0] out_data_reg, out_data_next;

	// Stage refills when empty or when its entry is being taken
	assign drain_ready = ~out_valid_reg | wr_ready_in;

	always_comb begin
		out_valid_next = out_valid_reg;
		out_addr_next = out_addr_reg;
		out_data_next = out_data_reg;
		if (drain_ready) begin
			out_valid_next = drain_valid;
			if (drain_valid) begin
				out_addr_next = drain_data[MSG_W-1:BYTE_W];
				out_data_next = drain_data[BYTE_W-1:0];
			end
		end
	end

	always_ff @(posedge clk_in or negedge core_rst_n) begin
		if (!core_rst_n) begin
			out_valid_reg <= 1'b0;
			out_addr_reg <= ADDR_RESET;
			out_data_reg <= REG_RESET;
		end else begin
			out_valid_reg <= out_valid_next;
			out_addr_reg <= out_addr_next;
			out_data_reg <= out_data_next;
		end
	end

	assign wr_valid_out = out_valid_reg;
	assign wr_addr_out = out_addr_reg;
	assign wr_data_out = out_data_reg;
endmodule

// >>> spi_port_pkg.sv
// Constants shared by the serial register access port and its FIFO
package spi_port_pkg;
	localparam int ADDR_W = 7;
	localparam int BYTE_W = 8;
	localparam int MSG_W = ADDR_W + BYTE_W;
	localparam int DOC_REG_COUNT = 128;
	localparam int DOC_FIFO_DEPTH = 8;
	localparam logic [ADDR_W-1:0] FIFO_ADDR = 7'h00;
	localparam logic [2:0] BIT_FIRST = 3'h0;
	localparam logic [2:0] BIT_LAST = 3'h7;
	localparam logic [BYTE_W-1:0] REG_RESET = 8'h00;
	localparam logic [BYTE_W-1:0] IDLE_BYTE = 8'h00;
	localparam logic [ADDR_W-1:0] ADDR_RESET = 7'h00;
	localparam logic [ADDR_W-1:0] ADDR_STEP = 7'h01;
	localparam logic [2:0] BIT_STEP = 3'h1;
endpackage

// >>> spi_port_fifo.sv
// Dual-clock FIFO with gray-coded pointers, valid and ready on both sides
module spi_port_fifo #(
	parameter int WIDTH = 15,
	parameter int DEPTH = 8
) (
	input wire logic wr_clk_in,
	input wire logic wr_rst_n_in,
	input wire logic wr_valid_in,
	input wire logic [WIDTH-1:0] wr_data_in,
	output logic wr_ready_out,
	input wire logic rd_clk_in,
	input wire logic rd_rst_n_in,
	output logic rd_valid_out,
	output logic [WIDTH-1:0] rd_data_out,
	input wire logic rd_ready_in
);
	localparam int AW = $clog2(DEPTH);

	if (DEPTH < 4 || (1 << AW) != DEPTH) begin : g_bad_depth
		$error("spi_port_fifo: DEPTH must be a power of two, at least 4");
	end

	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [AW:0] wbin_reg, wbin_next, wgray_reg, wgray_next;
	logic [AW:0] rbin_reg, rbin_next, rgray_reg, rgray_next;
	logic [AW:0] rgray_w1_reg, rgray_w2_reg;
	logic [AW:0] wgray_r1_reg, wgray_r2_reg;
	logic push, pop;

	////////////////////////////////////////////////////////////////////////
	// Write side
	assign wr_ready_out = wgray_reg !=
		{~rgray_w2_reg[AW:AW-1], rgray_w2_reg[AW-2:0]};
	assign push = wr_valid_in & wr_ready_out;

	always_comb begin
		wbin_next = wbin_reg + (AW+1)'(push);
		wgray_next = wbin_next ^ (wbin_next >> 1);
	end

	always_ff @(posedge wr_clk_in or negedge wr_rst_n_in) begin
		if (!wr_rst_n_in) begin
			wbin_reg <= '0;
			wgray_reg <= '0;
			rgray_w1_reg <= '0;
			rgray_w2_reg <= '0;
		end else begin
			wbin_reg <= wbin_next;
			wgray_reg <= wgray_next;
			rgray_w1_reg <= rgray_reg;
			rgray_w2_reg <= rgray_w1_reg;
		end
	end

	// Storage needs no reset; valid flags guard every read
	always_ff @(posedge wr_clk_in) begin
		if (push) begin
			mem_reg[wbin_reg[AW-1:0]] <= wr_data_in;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read side
	assign rd_valid_out = rgray_reg != wgray_r2_reg;
	assign rd_data_out = mem_reg[rbin_reg[AW-1:0]];
	assign pop = rd_valid_out & rd_ready_in;

	always_comb begin
		rbin_next = rbin_reg + (AW+1)'(pop);
		rgray_next = rbin_next ^ (rbin_next >> 1);
	end

	always_ff @(posedge rd_clk_in or negedge rd_rst_n_in) begin
		if (!rd_rst_n_in) begin
			rbin_reg <= '0;
			rgray_reg <= '0;
			wgray_r1_reg <= '0;
			wgray_r2_reg <= '0;
		end else begin
			rbin_reg <= rbin_next;
			rgray_reg <= rgray_next;
			wgray_r1_reg <= wgray_reg;
			wgray_r2_reg <= wgray_r1_reg;
		end
	end
endmodule

// >>> spi_port_sva.sv
// Concurrent checks on the serial register access port
module spi_port_sva
	import spi_port_pkg::*;
(
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic spi_clk_in,
	input wire logic chip_select_n_in,
	input wire logic miso_out,
	input wire logic miso_oe_out,
	input wire logic wr_valid_out,
	input wire logic [ADDR_W-1:0] wr_addr_out,
	input wire logic [BYTE_W-1:0] wr_data_out,
	input wire logic wr_ready_in,
	input wire logic rd_valid_in,
	input wire logic rd_ready_out
);
	logic [3:0] bit_reg;
	logic [3:0] bit_next;
	// Saturates so long bursts never wrap into the address phase
	always_comb begin
		bit_next = (bit_reg == 4'hF) ? bit_reg : bit_reg + 4'h1;
	end
	always_ff @(posedge spi_clk_in or posedge chip_select_n_in) begin
		if (chip_select_n_in) begin
			bit_reg <= 4'h0;
		end else begin
			bit_reg <= bit_next;
		end
	end
	////////////////////////////////////////////////////////////////////////
	oe_select_a: assert property (@(posedge clk_in)
		miso_oe_out == !chip_select_n_in) else $error("miso enable wrong");
	addr_byte_zero_a: assert property (@(posedge spi_clk_in)
		disable iff (chip_select_n_in || !rst_n_in)
		bit_reg < 4'h8 |-> miso_out == 1'b0) else $error("miso not zero");
	miso_fall_a: assert property (@(posedge clk_in)
		disable iff (!rst_n_in) spi_clk_in && $past(spi_clk_in)
		|-> $stable(miso_out)) else $error("miso moved while clock high");
	data_hold_a: assert property (@(posedge clk_in)
		disable iff (!rst_n_in) wr_valid_out && !wr_ready_in |=> wr_valid_out
		&& $stable({wr_addr_out, wr_data_out})) else $error("write not held");
	valid_drop_a: assert property (@(posedge clk_in)
		disable iff (!rst_n_in) $fell(wr_valid_out) |-> $past(wr_ready_in))
		else $error("write dropped unaccepted");
	reset_quiet_a: assert property (@(posedge clk_in)
		!rst_n_in |-> !wr_valid_out && wr_addr_out == ADDR_RESET
		&& wr_data_out == 8'h00) else $error("write side not idle");
	ready_drop_a: assert property (@(posedge clk_in)
		disable iff (!rst_n_in) $fell(rd_ready_out) |-> $past(rd_valid_in))
		else $error("ready fell without push");
	ready_reset_a: assert property (@(posedge clk_in)
		!rst_n_in |-> rd_ready_out) else $error("ready low in reset");
	cover property (@(posedge clk_in) wr_valid_out && wr_ready_in);
	cover property (@(posedge clk_in) !rd_ready_out);
	cover property (@(posedge spi_clk_in) bit_reg == 4'h9);
endmodule
bind spi_register_access_port spi_port_sva u_spi_port_sva (.clk_in,
	.rst_n_in, .spi_clk_in, .chip_select_n_in, .miso_out, .miso_oe_out,
	.wr_valid_out, .wr_addr_out, .wr_data_out, .wr_ready_in, .rd_valid_in,
	.rd_ready_out);

// >>> spi_master_model.sv
// Serial master model driving frames from the link clock
module spi_master_model (
	input wire logic link_clk_in,
	input wire logic miso_in,
	output logic sck_out,
	output logic cs_n_out,
	output logic mosi_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] tx_byte [16];
	logic [7:0] rx_byte [16];
	initial begin
		sck_out = 1'b0;
		cs_n_out = 1'b1;
		mosi_out = 1'b0;
	end
	// Clock stands low outside frames
	task automatic xfer(input int n);
		@(posedge link_clk_in) cs_n_out <= 1'b0;
		for (int i = 0; i < n; i++) begin
			for (int b = 7; b >= 0; b--) begin
				@(posedge link_clk_in) sck_out <= 1'b0;
				mosi_out <= tx_byte[i][b];
				@(posedge link_clk_in) sck_out <= 1'b1;
				rx_byte[i][b] = miso_in;
			end
		end
		@(posedge link_clk_in) sck_out <= 1'b0;
		@(posedge link_clk_in) cs_n_out <= 1'b1;
		mosi_out <= ~mosi_out;
	endtask
endmodule

// >>> testbench.sv
// Self-checking bench for the serial register access port
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	import spi_port_pkg::*;
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin fail_count++; \
	$display("MISMATCH %0t %h %h", $time, (a), (b)); end end
	logic clk_in, rst_n_in, link_clk, sck, cs_n, mosi, miso, miso_oe;
	logic wr_valid, wr_ready, rd_valid, rd_ready;
	logic [6:0] wr_addr, a;
	logic [7:0] wr_data, rd_data, d;
	int fail_count, checks, seed;
	logic [7:0] mem [128];
	logic [7:0] rdq [$];
	logic [14:0] wq [$];
	logic [14:0] wexp;
	logic miso_line;
	// Undriven line shows the inverse, so a missing enable is caught
	assign miso_line = miso_oe ? miso : ~miso;
	initial begin
		clk_in = 1'b0;
		forever #4 clk_in = ~clk_in;
	end
	initial begin
		link_clk = 1'b0;
		#3.3;
		forever #7.5 link_clk = ~link_clk;
	end
	spi_register_access_port u_spi_register_access_port (.clk_in(clk_in),
		.rst_n_in(rst_n_in), .spi_clk_in(sck), .chip_select_n_in(cs_n),
		.mosi_in(mosi), .miso_out(miso), .miso_oe_out(miso_oe),
		.wr_valid_out(wr_valid), .wr_addr_out(wr_addr), .wr_data_out(wr_data),
		.wr_ready_in(wr_ready), .rd_valid_in(rd_valid), .rd_data_in(rd_data),
		.rd_ready_out(rd_ready));
	spi_master_model u_spi_master_model (.link_clk_in(link_clk),
		.miso_in(miso_line), .sck_out(sck), .cs_n_out(cs_n),
		.mosi_out(mosi));
	////////////////////////////////////////////////////////////////////////
	always @(posedge clk_in) begin
		wr_ready <= $random(seed) & 1;
		if (rst_n_in && wr_valid && wr_ready) begin
			wexp = wq.size() ? wq.pop_front() : 15'h7FFF;
			`CHK({wr_addr, wr_data}, wexp)
		end
	end
	task automatic final_report;
		if (fail_count == 0 && checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	// Expectations are queued before the frame: notices arrive mid-frame
	task automatic frame(input logic w, input logic [6:0] adr, input int n);
		logic [7:0] ex [16];
		logic [6:0] p;
		p = adr;
		u_spi_master_model.tx_byte[0] = {w, adr};
		for (int i = 1; i <= n; i++) begin
			u_spi_master_model.tx_byte[i] = $random(seed);
			if (p == FIFO_ADDR) begin
				ex[i] = (!w && rdq.size()) ? rdq.pop_front() : 8'h00;
			end else begin
				ex[i] = mem[p];
			end
			if (w) begin
				mem[p] = u_spi_master_model.tx_byte[i];
				wq.push_back({p, mem[p]});
			end
			if (p != FIFO_ADDR) p = p + ADDR_STEP;
		end
		u_spi_master_model.xfer(n + 1);
		`CHK(u_spi_master_model.rx_byte[0], IDLE_BYTE)
		for (int i = 1; i <= n; i++) begin
			`CHK(u_spi_master_model.rx_byte[i], ex[i])
		end
	endtask
	initial begin
		seed = 32'hdbd6;
		rst_n_in = 1'b0;
		wr_ready = 1'b0;
		rd_valid = 1'b0;
		rd_data = 8'h00;
		foreach (mem[i]) mem[i] = REG_RESET;
		repeat (16) @(posedge clk_in);
		rst_n_in <= 1'b1;
		repeat (4) @(posedge clk_in);
		for (int k = 0; k < 6; k++) begin
			a = $random(seed);
			a = {1'b0, a[5:0]} + 7'h01;
			frame(1'b1, a, k + 1);
			frame(1'b0, a, k + 2);
		end
		@(posedge clk_in);
		for (int i = 0; i <= DOC_FIFO_DEPTH; i++) begin
			d = $random(seed);
			rd_valid <= 1'b1;
			rd_data <= d;
			@(negedge clk_in);
			`CHK(rd_ready, 1'(i < DOC_FIFO_DEPTH))
			if (rd_ready === 1'b1) rdq.push_back(d);
			@(posedge clk_in);
		end
		rd_valid <= 1'b0;
		frame(1'b0, FIFO_ADDR, DOC_FIFO_DEPTH + 1);
		frame(1'b1, FIFO_ADDR, 3);
		for (int i = 0; i < 400 && wq.size() != 0; i++) @(posedge clk_in);
		`CHK(wq.size(), 0)
		final_report();
	end
	// Whole run needs some 19 us; over six times that is ample
	initial begin
		#120000;
		fail_count++;
		final_report();
	end
endmodule
